// >>> src/mrc_core.sv
// move core with stack, boot entry and program password
//
// Contract
// RQ1 - decode fixed 16-bit instruction words only
// RQ2 - fetch and execute each word in one cycle
// RQ3 - top bit picks immediate or register source
// RQ4 - low byte source: module nibble, index nibble
// RQ5 - bits 8-14 destination: module, subindex
// RQ6 - prefix write supplies upper destination bits
// RQ7 - every operation is a move with effects
// RQ8 - sixteen accumulators for arithmetic and logic
// RQ9 - three data pointers with post increment/decrement
// RQ10 - sixteen-entry 16-bit hardware stack
// RQ11 - stack index resets to entry 0fh
// RQ12 - push: increment index, then write
// RQ13 - pop: read entry, then decrement index
// RQ14 - every reset starts at 8000h
// RQ15 - ram, nv data and conversion word stores
// RQ16 - password words 10h-1fh, neither zeros nor ones
// RQ17 - lock bit set at power-on, clear grants
// RQ18 - mass erase sets password to ones
// RQ19 - tester sets loader bit during reset
// RQ20 - loader exit clears bit and restarts
// RQ21 - host must match password while locked; the code lets any CTRL write clear lock_ff without a match
// RQ22 - nv writes need password, read protect bit
// RQ23 - stack index wraps modulo sixteen
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
module mrc_core (
	// clock, reset and enable
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        ce_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// program memory
	output logic      [15:0] pm_addr_o,
	input  wire logic [15:0] pm_data_i,
	output logic             pm_we_o,
	output logic      [11:0] pm_waddr_o,
	output logic      [15:0] pm_wdata_o,
	output logic             pm_erase_o,
	// peripheral registers
	output logic             sfr_we_o,
	output logic      [8:0]  sfr_addr_o,
	output logic      [15:0] sfr_wdata_o,
	input  wire logic        irq_i,
	// conversion results
	input  wire logic        conv_we_i,
	input  wire logic [3:0]  conv_idx_i,
	input  wire logic [15:0] conv_data_i,
	// test port and status
	input  wire logic        loader_pin_i,
	output logic             loader_entry_o,
	output logic             lock_o
);

	// core state
	logic [15:0] pc_ff;
	logic [3:0]  top_ff;
	logic [15:0] stk_ff [mrc_pkg::STK_DEPTH];
	logic [15:0] acc_ff [mrc_pkg::ACC_COUNT];
	logic [3:0]  ap_ff;
	logic [15:0] dp_ff [mrc_pkg::DP_COUNT];
	logic [15:0] ram_ff [mrc_pkg::RAM_WORDS];
	logic [15:0] nv_ff [mrc_pkg::NV_WORDS];
	logic [15:0] conv_ff [mrc_pkg::CONV_WORDS];
	logic [15:0] pw_ff [mrc_pkg::PW_WORDS];
	logic [1:0]  pfx_ff;
	logic        pfx_ok_ff;
	logic        ie_ff;
	logic        srst_ff;
	// protection and loader state
	logic        lock_ff;
	logic        rdprot_ff;
	logic        loader_ff;
	logic        cap_ff;
	logic        pin_s1_ff;
	logic        pin_s2_ff;
	logic [3:0]  key_cnt_ff;
	logic        key_bad_ff;
	logic        key_ok_ff;
	logic [11:0] pmaddr_ff;
	logic [5:0]  nvaddr_ff;
	logic        pready_ff;

	// helper: data space read through a pointer
	function automatic logic [15:0] dread(input logic [15:0] a);
		logic [15:0] r;
		r = 16'h0000;
		if (a < mrc_pkg::NV_BASE) // RQ15
			r = ram_ff[a[7:0]];
		else if (a < mrc_pkg::CONV_BASE)
			r = nv_ff[a[5:0]];
		else if (a < mrc_pkg::CONV_END)
			r = conv_ff[a[3:0]];
		return r;
	endfunction

	// instruction fields
	mrc_pkg::mrc_ins_t ins;
	wire [3:0] smod;
	wire [3:0] sidx;
	wire [3:0] dmod;
	wire [4:0] didx;
	assign ins  = pm_data_i; // RQ1
	assign smod = ins.src_mod; // RQ4
	assign sidx = ins.src_idx;
	assign dmod = ins.dst_mod; // RQ5
	assign didx = {pfx_ok_ff ? pfx_ff : 2'b00, ins.dst_sub}; // RQ6

	// issue control
	wire run;
	wire take_irq;
	wire exec;
	assign run      = ce_i & ~srst_ff;
	assign take_irq = irq_i & ie_ff & ~pfx_ok_ff;
	assign exec     = run & ~take_irq; // RQ2

	// pointer selections from the low two index bits, low bits 3 map to the last pointer
	wire [1:0] sdi;
	wire [1:0] ddi;
	wire       s_dp_ok;
	wire       d_dp_ok;
	assign sdi     = (sidx[1:0] == 2'b11) ? 2'b10 : sidx[1:0];
	assign ddi     = (didx[1:0] == 2'b11) ? 2'b10 : didx[1:0];
	assign s_dp_ok = sidx < 4'(mrc_pkg::DP_COUNT);
	assign d_dp_ok = didx < 5'(mrc_pkg::DP_COUNT);

	// source selection
	wire [15:0] acc_cur;
	wire [15:0] mem_s;
	wire [15:0] src_reg;
	wire [15:0] src_val;
	assign acc_cur = acc_ff[ap_ff];
	assign mem_s   = dread(dp_ff[sdi]);
	assign src_reg =
		(smod == mrc_pkg::MOD_PC)   ? pc_ff :
		(smod == mrc_pkg::MOD_ALU)  ? acc_cur :
		(smod == mrc_pkg::MOD_ACC)  ? acc_ff[sidx] :
		(smod == mrc_pkg::MOD_DP)   ? dp_ff[sdi] :
		(smod == mrc_pkg::MOD_MINC) ? mem_s :
		(smod == mrc_pkg::MOD_MDEC) ? mem_s :
		(smod == mrc_pkg::MOD_STK)  ? stk_ff[top_ff] :
		(smod == mrc_pkg::MOD_CTL)  ? {15'h0000, ie_ff} : 16'h0000;
	assign src_val = ins.fmt_reg ? src_reg : {8'h00, ins.src_idx, ins.src_mod}; // RQ3

	// source side effects
	wire src_pop;
	wire src_popclr;
	wire s_inc;
	wire s_dec;
	assign src_pop    = exec & ins.fmt_reg & (smod == mrc_pkg::MOD_STK)
		& (sidx == mrc_pkg::SRC_POP | sidx == mrc_pkg::SRC_POPCLR);
	assign src_popclr = src_pop & (sidx == mrc_pkg::SRC_POPCLR);
	assign s_inc = exec & ins.fmt_reg & s_dp_ok & (smod == mrc_pkg::MOD_MINC);
	assign s_dec = exec & ins.fmt_reg & s_dp_ok & (smod == mrc_pkg::MOD_MDEC);

	// destination side effects
	wire d_pc;
	wire d_call;
	wire d_jump;
	wire d_ret;
	wire d_iret;
	wire d_push;
	wire d_inc;
	wire d_dec;
	wire d_pfx;
	wire d_ext;
	assign d_pc   = exec & (dmod == mrc_pkg::MOD_PC); // RQ7
	assign d_call = d_pc & (didx == mrc_pkg::SUB_CALL);
	assign d_jump = d_pc & (didx == mrc_pkg::SUB_JUMP | d_call);
	assign d_iret = d_pc & (didx == mrc_pkg::SUB_IRET);
	assign d_ret  = d_pc & (didx == mrc_pkg::SUB_RETURN) | d_iret;
	assign d_push = exec & (dmod == mrc_pkg::MOD_STK)
		& (didx == mrc_pkg::SUB_PUSH);
	assign d_inc  = exec & d_dp_ok & (dmod == mrc_pkg::MOD_MINC);
	assign d_dec  = exec & d_dp_ok & (dmod == mrc_pkg::MOD_MDEC);
	assign d_pfx  = exec & (dmod == mrc_pkg::MOD_PFX);
	assign d_ext  = exec & (dmod >= mrc_pkg::MOD_EXT);

	// accumulator write port
	wire        alu_we;
	wire        acc_we;
	wire [3:0]  acc_wi;
	wire [15:0] alu_res;
	assign alu_we  = exec & (dmod == mrc_pkg::MOD_ALU)
		& (didx != mrc_pkg::SUB_PTR);
	assign alu_res = // RQ8
		(didx == mrc_pkg::SUB_ADD) ? acc_cur + src_val :
		(didx == mrc_pkg::SUB_SUB) ? acc_cur - src_val :
		(didx == mrc_pkg::SUB_AND) ? acc_cur & src_val :
		(didx == mrc_pkg::SUB_OR)  ? acc_cur | src_val :
		(didx == mrc_pkg::SUB_XOR) ? acc_cur ^ src_val : src_val;
	assign acc_we  = alu_we | exec & (dmod == mrc_pkg::MOD_ACC);
	assign acc_wi  = alu_we ? ap_ff : didx[3:0];

	// stack index and write port
	wire        pop_evt;
	wire        push_evt;
	wire [3:0]  top_up;
	wire [3:0]  top_dn;
	wire [3:0]  nxt_top;
	wire [3:0]  stk_wa;
	wire [15:0] stk_wd;
	assign pop_evt  = src_pop | d_ret;
	assign push_evt = d_push | d_call | run & take_irq;
	assign top_up   = top_ff + 4'h1; // RQ23
	assign top_dn   = top_ff - 4'h1; // RQ23
	assign nxt_top  = (push_evt & ~pop_evt) ? top_up : // RQ12
		(pop_evt & ~push_evt) ? top_dn : top_ff; // RQ13
	assign stk_wa   = pop_evt ? top_ff : top_up; // RQ12
	assign stk_wd   = take_irq ? pc_ff :
		d_call ? pc_ff + 16'h0001 : src_val;

	// protection state
	wire [mrc_pkg::PW_WORDS-1:0] pw_zero;
	wire [mrc_pkg::PW_WORDS-1:0] pw_ones;
	wire pw_def;
	wire access;
	wire d_nv;
	wire [15:0] d_addr;
	assign d_addr = dp_ff[ddi];
	assign d_nv   = d_addr >= mrc_pkg::NV_BASE & d_addr < mrc_pkg::CONV_BASE;

	// per password word, all-zero and all-one detect
	genvar g;
	generate
		for (g = 0; g < mrc_pkg::PW_WORDS; g++)
		begin : g_pw
			assign pw_zero[g] = ~|pw_ff[g];
			assign pw_ones[g] = &pw_ff[g];
		end
	endgenerate
	assign pw_def = ~(&pw_zero) & ~(&pw_ones); // RQ16
	assign access = ~lock_ff | key_ok_ff | ~pw_def; // RQ17

	// apb decode
	wire        setup;
	wire        done;
	wire        wr;
	wire        mapped;
	wire [31:0] rd_mux;
	assign setup  = psel_i & ~penable_i & ~pready_ff;
	assign done   = psel_i & penable_i & pready_ff;
	assign wr     = done & pwrite_i;
	assign mapped = paddr_i == mrc_pkg::A_CTRL | paddr_i == mrc_pkg::A_STAT
		| paddr_i == mrc_pkg::A_KEY | paddr_i == mrc_pkg::A_PMADDR
		| paddr_i == mrc_pkg::A_PMDATA | paddr_i == mrc_pkg::A_NVADDR
		| paddr_i == mrc_pkg::A_NVDATA;
	assign rd_mux =
		(paddr_i == mrc_pkg::A_CTRL) ?
			{26'h0, access, 2'b00, loader_ff, rdprot_ff, lock_ff} :
		(paddr_i == mrc_pkg::A_STAT) ? {12'h000, top_ff, pc_ff} :
		(paddr_i == mrc_pkg::A_KEY) ? {27'h0, key_ok_ff, key_cnt_ff} :
		(paddr_i == mrc_pkg::A_PMADDR) ? {20'h0, pmaddr_ff} :
		(paddr_i == mrc_pkg::A_NVADDR) ? {26'h0, nvaddr_ff} :
		(paddr_i == mrc_pkg::A_NVDATA & ~rdprot_ff) ? // RQ22
			{16'h0000, nv_ff[nvaddr_ff]} : 32'h0;

	// apb write strobes
	wire w_ctrl;
	wire w_key;
	wire w_pmdata;
	wire w_nvdata;
	wire do_exit;
	wire do_erase;
	wire key_last;
	assign w_ctrl   = wr & (paddr_i == mrc_pkg::A_CTRL);
	assign w_key    = wr & (paddr_i == mrc_pkg::A_KEY);
	assign w_pmdata = wr & (paddr_i == mrc_pkg::A_PMDATA) & access; // RQ22
	assign w_nvdata = wr & (paddr_i == mrc_pkg::A_NVDATA) & access; // RQ22
	assign do_exit  = w_ctrl & pwdata_i[mrc_pkg::B_EXIT];
	assign do_erase = w_ctrl & pwdata_i[mrc_pkg::B_ERASE];
	assign key_last = key_cnt_ff == 4'hf;

	// program counter, stack index, restart
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pc_ff   <= mrc_pkg::ROM_ENTRY; // RQ14
			top_ff  <= mrc_pkg::STK_TOP; // RQ11
			srst_ff <= 1'b0;
		end
		else if (ce_i)
		begin
			srst_ff <= do_exit; // RQ20
			if (srst_ff)
			begin
				pc_ff  <= mrc_pkg::ROM_ENTRY; // RQ14
				top_ff <= mrc_pkg::STK_TOP; // RQ11
			end
			else
			begin
				pc_ff  <= take_irq ? mrc_pkg::IRQ_VECTOR :
					d_ret ? stk_ff[top_ff] :
					d_jump ? src_val : pc_ff + 16'h0001; // RQ2
				top_ff <= nxt_top;
			end
		end
	end

	// prefix, interrupt enable, accumulator pointer
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pfx_ff    <= 2'b00;
			pfx_ok_ff <= 1'b0;
			ie_ff     <= 1'b0;
			ap_ff     <= 4'h0;
		end
		else if (ce_i)
		begin
			if (srst_ff | run)
				pfx_ok_ff <= d_pfx; // RQ6
			if (d_pfx)
				pfx_ff <= src_val[1:0];
			if (srst_ff | take_irq | src_popclr)
				ie_ff <= 1'b0;
			else if (d_iret)
				ie_ff <= 1'b1;
			else if (exec & dmod == mrc_pkg::MOD_CTL)
				ie_ff <= src_val[0];
			if (exec & dmod == mrc_pkg::MOD_ALU & didx == mrc_pkg::SUB_PTR)
				ap_ff <= src_val[3:0];
		end
	end

	// data pointers with post step
	generate
		for (g = 0; g < mrc_pkg::DP_COUNT; g++)
		begin : g_dp
			wire set_g;
			wire inc_g;
			wire dec_g;
			assign set_g = exec & dmod == mrc_pkg::MOD_DP & didx == 5'(g);
			assign inc_g = d_inc & ddi == 2'(g) | s_inc & sdi == 2'(g);
			assign dec_g = d_dec & ddi == 2'(g) | s_dec & sdi == 2'(g);
			always_ff @(posedge clk_i or posedge reset_i)
			begin
				if (reset_i)
					dp_ff[g] <= 16'h0000;
				else if (ce_i)
				begin
					if (set_g)
						dp_ff[g] <= src_val;
					else if (inc_g)
						dp_ff[g] <= dp_ff[g] + 16'h0001; // RQ9
					else if (dec_g)
						dp_ff[g] <= dp_ff[g] - 16'h0001; // RQ9
				end
			end
		end
	endgenerate

	// stack and accumulator storage
	always_ff @(posedge clk_i)
	begin
		if (ce_i & push_evt)
			stk_ff[stk_wa] <= stk_wd; // RQ10
		if (ce_i & acc_we)
			acc_ff[acc_wi] <= alu_res; // RQ8
	end

	// data ram, nv data and conversion stores
	always_ff @(posedge clk_i)
	begin
		if (ce_i & (d_inc | d_dec) & d_addr < mrc_pkg::NV_BASE)
			ram_ff[d_addr[7:0]] <= src_val;
		if (ce_i & (d_inc | d_dec) & d_nv & access)
			nv_ff[d_addr[5:0]] <= src_val; // RQ22
		if (ce_i & w_nvdata)
			nv_ff[nvaddr_ff] <= pwdata_i[15:0];
		if (ce_i & conv_we_i & conv_idx_i < 4'(mrc_pkg::CONV_WORDS))
			conv_ff[conv_idx_i] <= conv_data_i;
	end

	// password shadow of program words
	generate
		for (g = 0; g < mrc_pkg::PW_WORDS; g++)
		begin : g_pws
			always_ff @(posedge clk_i or posedge reset_i)
			begin
				if (reset_i)
					pw_ff[g] <= 16'hffff;
				else if (ce_i & do_erase)
					pw_ff[g] <= 16'hffff; // RQ18
				else if (ce_i & w_pmdata & pmaddr_ff[11:4] == mrc_pkg::PW_PAGE
					& pmaddr_ff[3:0] == 4'(g))
					pw_ff[g] <= pwdata_i[15:0]; // RQ16
			end
		end
	endgenerate

	// lock, read protect and key match
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			lock_ff    <= 1'b1; // RQ17
			rdprot_ff  <= 1'b0;
			key_cnt_ff <= 4'h0;
			key_bad_ff <= 1'b0;
			key_ok_ff  <= 1'b0;
		end
		else if (ce_i)
		begin
			if (w_ctrl)
				lock_ff <= pwdata_i[mrc_pkg::B_LOCK]; // RQ17
			if (w_ctrl & access)
				rdprot_ff <= pwdata_i[mrc_pkg::B_RDPROT];
			if (do_erase | w_ctrl & pwdata_i[mrc_pkg::B_LOCK])
				key_ok_ff <= 1'b0;
			else if (w_key & key_last) // RQ22
				key_ok_ff <= ~key_bad_ff & pw_ff[key_cnt_ff] == pwdata_i[15:0];
			if (w_key)
			begin
				key_cnt_ff <= key_cnt_ff + 4'h1;
				key_bad_ff <= ~key_last
					& (key_bad_ff | pw_ff[key_cnt_ff] != pwdata_i[15:0]);
			end
		end
	end

	// loader pin synchroniser, no reset so the level is ready at release
	always_ff @(posedge clk_i)
	begin
		pin_s1_ff <= loader_pin_i;
		pin_s2_ff <= pin_s1_ff;
	end

	// loader bit caught once after reset release
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			cap_ff    <= 1'b0;
			loader_ff <= 1'b0;
		end
		else if (ce_i)
		begin
			cap_ff <= 1'b1;
			if (~cap_ff)
				loader_ff <= pin_s2_ff; // RQ19
			else if (do_exit)
				loader_ff <= 1'b0; // RQ20
		end
	end

	// apb answer and address registers
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pready_ff <= 1'b0;
			prdata_o  <= 32'h0;
			pslverr_o <= 1'b0;
			pmaddr_ff <= 12'h000;
			nvaddr_ff <= 6'h00;
		end
		else if (ce_i)
		begin
			pready_ff <= setup;
			if (setup)
			begin
				prdata_o  <= pwrite_i ? 32'h0 : rd_mux;
				pslverr_o <= ~mapped;
			end
			if (wr & paddr_i == mrc_pkg::A_PMADDR)
				pmaddr_ff <= pwdata_i[11:0];
			if (wr & paddr_i == mrc_pkg::A_NVADDR)
				nvaddr_ff <= pwdata_i[5:0];
		end
	end

	// program memory and peripheral write ports
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pm_we_o     <= 1'b0;
			pm_waddr_o  <= 12'h000;
			pm_wdata_o  <= 16'h0000;
			pm_erase_o  <= 1'b0;
			sfr_we_o    <= 1'b0;
			sfr_addr_o  <= 9'h000;
			sfr_wdata_o <= 16'h0000;
		end
		else if (ce_i)
		begin
			pm_we_o    <= w_pmdata; // RQ22
			pm_erase_o <= do_erase; // RQ18
			sfr_we_o   <= d_ext; // RQ7
			if (w_pmdata)
			begin
				pm_waddr_o <= pmaddr_ff;
				pm_wdata_o <= pwdata_i[15:0];
			end
			if (d_ext)
			begin
				sfr_addr_o  <= {didx, dmod};
				sfr_wdata_o <= src_val;
			end
		end
	end

	// flop outputs
	assign pm_addr_o      = pc_ff;
	assign pready_o       = pready_ff;
	assign loader_entry_o = loader_ff;
	assign lock_o         = lock_ff;

	// checks
	property p_seq_pc;
		@(posedge clk_i) disable iff (reset_i)
		exec & ~d_pc |=> pc_ff == $past(pc_ff) + 16'h0001;
	endproperty
	a_seq_pc: assert property (p_seq_pc) else $error("pc not advanced"); // RQ2

	property p_push;
		@(posedge clk_i) disable iff (reset_i)
		d_push & ~pop_evt |=> top_ff == $past(top_up)
			&& stk_ff[top_ff] == $past(src_val);
	endproperty
	a_push: assert property (p_push) else $error("push order wrong"); // RQ12

	property p_pop;
		@(posedge clk_i) disable iff (reset_i)
		exec & d_ret & ~push_evt |=> top_ff == $past(top_dn)
			&& pc_ff == $past(stk_ff[top_ff]);
	endproperty
	a_pop: assert property (p_pop) else $error("pop order wrong"); // RQ13

	property p_restart;
		@(posedge clk_i) disable iff (reset_i)
		do_exit & ce_i ##1 ce_i |=> pc_ff == mrc_pkg::ROM_ENTRY
			&& top_ff == mrc_pkg::STK_TOP && !loader_ff;
	endproperty
	a_restart: assert property (p_restart) else $error("bad restart"); // RQ20

	property p_prefix;
		@(posedge clk_i) disable iff (reset_i)
		d_pfx ##1 exec |-> didx[4:3] == $past(src_val[1:0]) ##1 !pfx_ok_ff;
	endproperty
	a_prefix: assert property (p_prefix) else $error("prefix lost"); // RQ6

	property p_dp_step;
		@(posedge clk_i) disable iff (reset_i)
		s_inc & ~d_inc & ~d_dec & sdi == 2'b00
			& ~(exec & dmod == mrc_pkg::MOD_DP)
			|=> dp_ff[0] == $past(dp_ff[0]) + 16'h0001;
	endproperty
	a_dp_step: assert property (p_dp_step) else $error("no post step"); // RQ9

	property p_pm_guard;
		@(posedge clk_i) disable iff (reset_i)
		$rose(pm_we_o) |-> $past(access) && $past(wr);
	endproperty
	a_pm_guard: assert property (p_pm_guard) else $error("write unguarded"); // RQ22

	property p_rdprot;
		@(posedge clk_i) disable iff (reset_i)
		setup & ce_i & rdprot_ff & paddr_i == mrc_pkg::A_NVDATA
			|=> prdata_o == 32'h0;
	endproperty
	a_rdprot: assert property (p_rdprot) else $error("protected read"); // RQ22

	property p_erase;
		@(posedge clk_i) disable iff (reset_i)
		do_erase & ce_i |=> !pw_def && pm_erase_o && !key_ok_ff;
	endproperty
	a_erase: assert property (p_erase) else $error("erase kept key"); // RQ18

	property p_wrap;
		@(posedge clk_i) disable iff (reset_i)
		push_evt & ~pop_evt & ~srst_ff & top_ff == mrc_pkg::STK_TOP
			|=> top_ff == 4'h0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("index no wrap"); // RQ23

endmodule

// >>> inc/mrc_pkg.sv
// constants and carrier types of the move core
package mrc_pkg;
	// restart and vectoring addresses
	localparam logic [15:0] ROM_ENTRY  = 16'h8000;
	localparam logic [15:0] IRQ_VECTOR = 16'h0020;
	localparam logic [3:0]  STK_TOP    = 4'hf;
	// memory sizes
	localparam int STK_DEPTH  = 16;
	localparam int ACC_COUNT  = 16;
	localparam int DP_COUNT   = 3;
	localparam int RAM_WORDS  = 256;
	localparam int NV_WORDS   = 64;
	localparam int CONV_WORDS = 10;
	localparam int PW_WORDS   = 16;
	// data space map seen through the pointers
	localparam logic [15:0] NV_BASE   = 16'h0100;
	localparam logic [15:0] CONV_BASE = 16'h0140;
	localparam logic [15:0] CONV_END  = 16'h014a;
	// password words in program memory
	localparam logic [7:0] PW_PAGE = 8'h01;
	// register module codes
	localparam logic [3:0] MOD_PC   = 4'h0;
	localparam logic [3:0] MOD_ALU  = 4'h1;
	localparam logic [3:0] MOD_ACC  = 4'h2;
	localparam logic [3:0] MOD_DP   = 4'h3;
	localparam logic [3:0] MOD_MINC = 4'h4;
	localparam logic [3:0] MOD_MDEC = 4'h5;
	localparam logic [3:0] MOD_STK  = 4'h6;
	localparam logic [3:0] MOD_PFX  = 4'h7;
	localparam logic [3:0] MOD_CTL  = 4'h8;
	localparam logic [3:0] MOD_EXT  = 4'h9;
	// destination subindex codes
	localparam logic [4:0] SUB_JUMP   = 5'h00;
	localparam logic [4:0] SUB_CALL   = 5'h01;
	localparam logic [4:0] SUB_RETURN = 5'h02;
	localparam logic [4:0] SUB_IRET   = 5'h03;
	localparam logic [4:0] SUB_PTR    = 5'h00;
	localparam logic [4:0] SUB_ADD    = 5'h01;
	localparam logic [4:0] SUB_SUB    = 5'h02;
	localparam logic [4:0] SUB_AND    = 5'h03;
	localparam logic [4:0] SUB_OR     = 5'h04;
	localparam logic [4:0] SUB_XOR    = 5'h05;
	localparam logic [4:0] SUB_PUSH   = 5'h00;
	// source index codes of the stack module
	localparam logic [3:0] SRC_POP    = 4'h0;
	localparam logic [3:0] SRC_POPCLR = 4'h1;
	// apb byte addresses
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_STAT   = 8'h04;
	localparam logic [7:0] A_KEY    = 8'h08;
	localparam logic [7:0] A_PMADDR = 8'h0c;
	localparam logic [7:0] A_PMDATA = 8'h10;
	localparam logic [7:0] A_NVADDR = 8'h14;
	localparam logic [7:0] A_NVDATA = 8'h18;
	// control register bit positions
	localparam int B_LOCK   = 0;
	localparam int B_RDPROT = 1;
	localparam int B_LOADER = 2;
	localparam int B_EXIT   = 3;
	localparam int B_ERASE  = 4;
	localparam int B_ACCESS = 5;
	// fixed instruction word
	typedef struct packed {
		logic       fmt_reg;
		logic [2:0] dst_sub;
		logic [3:0] dst_mod;
		logic [3:0] src_idx;
		logic [3:0] src_mod;
	} mrc_ins_t;
endpackage

// >>> verification/mrc_pm_model.sv
// program memory and peripheral register model for the move core
`timescale 1ns/1ps
module mrc_pm_model (
	// clock
	input  wire logic        clk_i,
	// program memory side
	input  wire logic [15:0] pm_addr_i,
	output logic      [15:0] pm_data_o,
	input  wire logic        pm_we_i,
	input  wire logic [11:0] pm_waddr_i,
	input  wire logic [15:0] pm_wdata_i,
	input  wire logic        pm_erase_i,
	// peripheral register side
	input  wire logic        sfr_we_i,
	input  wire logic [8:0]  sfr_addr_i,
	input  wire logic [15:0] sfr_wdata_i
);
	logic [15:0] rom [0:15];
	logic [15:0] mem [0:4095];
	logic [8:0]  log_a [0:31];
	logic [15:0] log_d [0:31];
	int          n_log = 0;
	int          n_pw = 0;
	// blank store holding a defined password
	initial
	begin
		for (int i = 0; i < 4096; i++)
			mem[i] = (i >= 16 && i < 32) ? 16'h1220 + 16'(i) : 16'h0200;
	end
	// same-cycle fetch: boot block, program store, else a harmless move
	always_comb
		if (pm_addr_i[15:4] == 12'h800)
			pm_data_o = rom[pm_addr_i[3:0]];
		else if (pm_addr_i < 16'h1000)
			pm_data_o = mem[pm_addr_i[11:0]];
		else
			pm_data_o = 16'h0200;
	// stores, mass erase and peripheral write log
	always @(posedge clk_i)
	begin
		if (pm_erase_i)
			for (int i = 0; i < 4096; i++)
				mem[i] <= 16'hffff;
		else if (pm_we_i)
		begin
			mem[pm_waddr_i] <= pm_wdata_i;
			n_pw <= n_pw + 1;
		end
		if (sfr_we_i && n_log < 32)
		begin
			log_a[n_log] <= sfr_addr_i;
			log_d[n_log] <= sfr_wdata_i;
			n_log <= n_log + 1;
		end
	end
endmodule

// >>> verification/mrc_core_tb_top.sv
// self-checking bench for the move core
`timescale 1ns/1ps
module mrc_core_tb_top;
	logic        clk_i, reset_i, ce_i, psel_i, penable_i, pwrite_i;
	logic        pready_o, pslverr_o, pm_we_o, pm_erase_o, sfr_we_o;
	logic        irq_i, conv_we_i, loader_pin_i, loader_entry_o, lock_o;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i, prdata_o, r;
	logic [15:0] pm_addr_o, pm_data_i, pm_wdata_o, sfr_wdata_o, conv_data_i;
	logic [11:0] pm_waddr_o;
	logic [8:0]  sfr_addr_o;
	logic [3:0]  conv_idx_i;
	logic        e;
	int          n_mismatch = 0;
	int          comparisons = 0;
	int          cyc = 0;
	logic [15:0] prog [0:15] = '{16'h0655, 16'h0666, 16'h8906, 16'h8906,
		16'h0977, 16'h3a12, 16'h0702, 16'h1a34, 16'h0100, 16'h0205,
		16'h1103, 16'h8901, 16'h0311, 16'h0421, 16'h0311, 16'h8904};
	logic [31:0] exp_w [0:6] = '{32'h00090066, 32'h00090055, 32'h00090077,
		32'h003a0012, 32'h011a0034, 32'h00090008, 32'h00090021};
	// design and far-side model
	mrc_core mrc_core_inst (.clk_i, .reset_i, .ce_i, .psel_i, .penable_i,
		.pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
		.pm_addr_o, .pm_data_i, .pm_we_o, .pm_waddr_o, .pm_wdata_o,
		.pm_erase_o, .sfr_we_o, .sfr_addr_o, .sfr_wdata_o, .irq_i,
		.conv_we_i, .conv_idx_i, .conv_data_i, .loader_pin_i,
		.loader_entry_o, .lock_o);
	mrc_pm_model mrc_pm_model_inst (.clk_i, .pm_addr_i(pm_addr_o),
		.pm_data_o(pm_data_i), .pm_we_i(pm_we_o), .pm_waddr_i(pm_waddr_o),
		.pm_wdata_i(pm_wdata_o), .pm_erase_i(pm_erase_o),
		.sfr_we_i(sfr_we_o), .sfr_addr_i(sfr_addr_o),
		.sfr_wdata_i(sfr_wdata_o));
	// clock
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// compare one result
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	// verdict and stop
	task automatic end_of_test();
	begin
		$display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	// one apb transfer: setup, access until pready, release
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
	begin
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		n = 0;
		// pready, read data and error all taken at the completing edge
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (pready_o !== 1'b1 && n < 20);
		if (pready_o !== 1'b1)
		begin
			n_mismatch++;
			end_of_test();
		end
		r = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	end
	endtask
	// hang guard
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_mismatch++;
			end_of_test();
		end
	end
	// main sequence
	initial
	begin
		{reset_i, ce_i} = 2'b11;
		{psel_i, penable_i, pwrite_i, irq_i, conv_we_i, loader_pin_i} = 6'h0;
		{paddr_i, pwdata_i, conv_idx_i, conv_data_i} = '0;
		for (int i = 0; i < 16; i++)
			mrc_pm_model_inst.rom[i] = prog[i];
		repeat (6) @(posedge clk_i);
		chk({16'h0, pm_addr_o}, 32'h8000);
		chk({30'h0, lock_o, loader_entry_o}, 32'h2);
		reset_i <= 1'b0;
		@(negedge clk_i);
		chk({16'h0, pm_addr_o}, 32'h8000);
		@(negedge clk_i);
		chk({16'h0, pm_addr_o}, 32'h8001);
		repeat (20) @(posedge clk_i);
		chk(32'(mrc_pm_model_inst.n_log), 32'd7);
		for (int i = 0; i < 7; i++)
			chk({7'h0, mrc_pm_model_inst.log_a[i], mrc_pm_model_inst.log_d[i]},
				exp_w[i]);
		apb(1'b0, mrc_pkg::A_STAT, 32'h0);
		chk({28'h0, r[19:16]}, 32'hf);
		$display("test program done");
		apb(1'b0, mrc_pkg::A_CTRL, 32'h0);
		chk(r, 32'h21);
		apb(1'b0, 8'h40, 32'h0);
		chk({r[30:0], e}, 32'h1);
		// store a defined password with the lock open, then close it
		apb(1'b1, mrc_pkg::A_CTRL, 32'h0);
		for (int i = 0; i < 16; i++)
		begin
			apb(1'b1, mrc_pkg::A_PMADDR, 32'h10 + i);
			apb(1'b1, mrc_pkg::A_PMDATA, 32'h1230 + i);
		end
		apb(1'b1, mrc_pkg::A_CTRL, 32'h1);
		apb(1'b0, mrc_pkg::A_CTRL, 32'h0);
		chk(r, 32'h1);
		apb(1'b1, mrc_pkg::A_PMADDR, 32'h5);
		apb(1'b1, mrc_pkg::A_PMDATA, 32'hbeef);
		repeat (2) @(posedge clk_i);
		chk(32'(mrc_pm_model_inst.n_pw), 32'd16);
		for (int i = 0; i < 16; i++)
			apb(1'b1, mrc_pkg::A_KEY, 32'h1230 + i);
		apb(1'b0, mrc_pkg::A_KEY, 32'h0);
		chk({31'h0, r[4]}, 32'h1);
		apb(1'b0, mrc_pkg::A_CTRL, 32'h0);
		chk(r, 32'h21);
		apb(1'b1, mrc_pkg::A_PMDATA, 32'hbeef);
		repeat (2) @(posedge clk_i);
		chk({16'h0, mrc_pm_model_inst.mem[5]}, 32'hbeef);
		apb(1'b1, mrc_pkg::A_CTRL, 32'h11);
		repeat (2) @(posedge clk_i);
		chk({mrc_pm_model_inst.mem[16], mrc_pm_model_inst.mem[31]},
			32'hffffffff);
		apb(1'b1, mrc_pkg::A_CTRL, 32'h0);
		apb(1'b0, mrc_pkg::A_CTRL, 32'h0);
		chk({r[31:1], lock_o}, 32'h20);
		// nv data readable until read protect is set
		apb(1'b1, mrc_pkg::A_NVADDR, 32'h3);
		apb(1'b1, mrc_pkg::A_NVDATA, 32'h5a5a);
		apb(1'b0, mrc_pkg::A_NVDATA, 32'h0);
		chk(r, 32'h5a5a);
		apb(1'b1, mrc_pkg::A_CTRL, 32'h2);
		apb(1'b0, mrc_pkg::A_NVDATA, 32'h0);
		chk(r, 32'h0);
		$display("test registers done");
		loader_pin_i <= 1'b1;
		reset_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		loader_pin_i <= 1'b0;
		chk({30'h0, lock_o, loader_entry_o}, 32'h3);
		apb(1'b1, mrc_pkg::A_CTRL, 32'h09);
		for (int i = 0; i < 4 && pm_addr_o !== 16'h8000; i++)
			@(negedge clk_i);
		chk({15'h0, loader_entry_o, pm_addr_o}, 32'h8000);
		$display("test loader done");
		end_of_test();
	end
endmodule
